// *** core/psi5_content_pkg.sv ***
// constants and carrier types for the psi5 frame content block
package psi5_content_pkg;

  localparam logic [7:0]  OFS_OUT_CFG    = 8'h00;
  localparam logic [7:0]  OFS_PROTO1     = 8'h04;
  localparam logic [7:0]  OFS_PROTO2     = 8'h08;
  localparam logic [7:0]  OFS_CTRL       = 8'h0c;
  localparam logic [7:0]  OFS_STATUS     = 8'h10;
  localparam logic [7:0]  OFS_ACTIVE_CFG = 8'h14;

  localparam logic [15:0] OUT_CFG_RST    = 16'h0000;
  localparam logic [15:0] PROTO1_RST     = 16'h0000;
  localparam logic [15:0] PROTO2_RST     = 16'h0000;

  localparam int BIT_CHANNELS   = 15;
  localparam int BIT_PARITY     = 14;
  localparam int BIT_SYNC       = 13;
  localparam int BIT_BAUD       = 12;
  localparam int BIT_CURRENT    = 11;
  localparam int BIT_STATUS_EN  = 10;
  localparam int BIT_ERR_STATUS = 9;
  localparam int BIT_THIRD_SLOT = 8;
  localparam int RATE_HI        = 7;
  localparam int RATE_LO        = 6;
  localparam int NIB_HI         = 5;
  localparam int NIB_LO         = 4;
  localparam int PAD_HI         = 3;
  localparam int PAD_LO         = 0;
  localparam int REP_HI         = 15;
  localparam int REP_LO         = 9;
  localparam int BIT_DETAIL_SEL = 7;
  localparam int CTRL_RUN       = 0;
  localparam int CTRL_PH3_EN    = 1;

  localparam logic [9:0]  CODE_READY  = 10'h1e7;
  localparam logic [9:0]  CODE_DEFECT = 10'h1f4;
  localparam logic [4:0]  PAD_BASE    = 5'h09;
  localparam logic [4:0]  PH3_WIDTH   = 5'h10;

  localparam int CLK_HZ       = 125_000_000;
  localparam int BAUD_LO_BPS  = 125_000;
  localparam int BAUD_HI_BPS  = 189_000;
  localparam int BIT_CYC_LO   = CLK_HZ / BAUD_LO_BPS;
  localparam int BIT_CYC_HI   = CLK_HZ / BAUD_HI_BPS;
  localparam int PERIOD0_US   = 1000;
  localparam int PERIOD1_US   = 500;
  localparam int PERIOD2_US   = 300;
  localparam int PERIOD3_US   = 250;
  localparam int CYC_PER_US   = CLK_HZ / 1_000_000;

  typedef struct packed {
    logic       over_temp;
    logic       under_volt;
    logic       over_volt;
    logic       magnet_lost;
    logic       clipping;
    logic       memory_err;
  } diag_t;

  typedef struct packed {
    logic [23:0] data;
    logic [4:0]  width;
    logic [1:0]  slot;
    logic        is_speed;
    logic        phase3;
    logic        status_en;
    logic        frame_error_flag;
    logic        parity_sel;
  } frame_t;

  typedef struct packed {
    logic        baud_hi;
    logic        current_double;
    logic        sync_mode;
    logic [2:0]  nibble_reps;
  } line_cfg_t;

endpackage : psi5_content_pkg

// *** core/psi5_frame_content.sv ***
// psi5 frame content builder with output configuration registers
//
// Decided for this implementation: the address map and the plain strobed port.
module psi5_frame_content
  import psi5_content_pkg::*;
#(
  parameter int PERIOD0_CYC = PERIOD0_US * CYC_PER_US,
  parameter int PERIOD1_CYC = PERIOD1_US * CYC_PER_US,
  parameter int PERIOD2_CYC = PERIOD2_US * CYC_PER_US,
  parameter int PERIOD3_CYC = PERIOD3_US * CYC_PER_US
)
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [15:0] rdata,
  input  wire logic [15:0] position_data,
  input  wire logic [15:0] speed_data,
  input  wire diag_t       diag_flags,
  input  wire logic        sync_pin,
  output frame_t           frame,
  output logic             frame_valid,
  output line_cfg_t        line_cfg,
  output logic             bit_tick
);

  localparam int PW = 18;

  initial
  begin
    // a three-slot group must end before the next period expires
    if (PERIOD0_CYC < 4 || PERIOD1_CYC < 4 || PERIOD2_CYC < 4 || PERIOD3_CYC < 4)
      $error("period counts must be at least four cycles");
    if (BIT_CYC_LO > 1024 || BIT_CYC_HI > 1024 || BIT_CYC_HI < 2)
      $error("bit period counts do not fit the bit counter");
    if (CYC_PER_US < 1)
      $error("clock too slow for the period counts");
    if (PERIOD0_CYC >= (1 << PW) || PERIOD1_CYC >= (1 << PW) ||
        PERIOD2_CYC >= (1 << PW) || PERIOD3_CYC >= (1 << PW))
      $error("period counts exceed the period counter width");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_EMIT} state_t;

  // software-written registers
  logic [15:0] out_cfg_r;
  logic [15:0] proto1_r;
  logic [15:0] proto2_r;
  logic [1:0]  ctrl_r;
  // copies taken every cycle outside emission, held while a group is emitted
  logic [15:0] act_cfg_r;
  logic        act_detail_r;

  state_t      state_r;
  state_t      state_nxt;
  logic        ph3_r;
  logic [8:0]  ph3_left_r;
  logic [1:0]  slot_r;
  logic [PW-1:0] period_cnt_r;
  logic [9:0]  bit_cnt_r;
  logic        sync_m_r;
  logic        sync_s_r;
  logic        sync_d_r;
  logic        run_d_r;

  logic [15:0] rdata_r;
  frame_t      frame_r;
  logic        frame_valid_r;
  line_cfg_t   line_cfg_r;
  logic        bit_tick_r;

  // register decode
  wire         wr_out_cfg = wr_stb && (addr == OFS_OUT_CFG);
  wire         wr_proto1  = wr_stb && (addr == OFS_PROTO1);
  wire         wr_proto2  = wr_stb && (addr == OFS_PROTO2);
  wire         wr_ctrl    = wr_stb && (addr == OFS_CTRL);
  wire  [15:0] status_word = {2'b00, ph3_left_r, ph3_r, slot_r, state_r};
  wire  [15:0] rd_mux =
      (addr == OFS_OUT_CFG)    ? out_cfg_r :
      (addr == OFS_PROTO1)     ? proto1_r :
      (addr == OFS_PROTO2)     ? proto2_r :
      (addr == OFS_CTRL)       ? {14'h0000, ctrl_r} :
      (addr == OFS_STATUS)     ? status_word :
      (addr == OFS_ACTIVE_CFG) ? act_cfg_r : 16'h0000;

  // triggers
  wire         run_en     = ctrl_r[CTRL_RUN];
  wire         run_rise   = run_en && !run_d_r;
  wire         sync_edge  = sync_s_r && !sync_d_r;
  wire         sync_mode  = act_cfg_r[BIT_SYNC];
  wire         period_hit = (period_cnt_r == '0);
  wire         trigger    = sync_mode ? sync_edge : period_hit;

  wire  [1:0]  rate_code  = act_cfg_r[RATE_HI:RATE_LO];
  wire [PW-1:0] period_load =
      (rate_code == 2'b00) ? PW'(PERIOD0_CYC - 1) :
      (rate_code == 2'b01) ? PW'(PERIOD1_CYC - 1) :
      (rate_code == 2'b10) ? PW'(PERIOD2_CYC - 1) : PW'(PERIOD3_CYC - 1);

  wire  [9:0]  bit_load   = out_cfg_r[BIT_BAUD] ? 10'(BIT_CYC_HI - 1) : 10'(BIT_CYC_LO - 1);
  wire         bit_hit    = (bit_cnt_r == 10'h000);

  wire         two_ch     = act_cfg_r[BIT_CHANNELS];
  wire         third      = act_cfg_r[BIT_THIRD_SLOT];
  wire  [1:0]  last_slot  = ph3_r ? 2'd0 : (!two_ch ? 2'd0 : (third ? 2'd2 : 2'd1));
  wire         slot_speed = two_ch && !ph3_r && (third ? (slot_r == 2'd2) : (slot_r == 2'd1));

  // padded data region width and mask
  wire  [4:0]  region_w   = PAD_BASE + {1'b0, act_cfg_r[PAD_HI:PAD_LO]};
  wire  [23:0] region_msk = ~(24'hffffff >> region_w);

  wire         fault      = |diag_flags;
  // diagnosis flags in fixed order below the code
  wire  [5:0]  diag_bits  = {diag_flags.over_temp, diag_flags.under_volt,
                             diag_flags.over_volt, diag_flags.magnet_lost,
                             diag_flags.clipping, diag_flags.memory_err};
  // msb-justified layout; mask drops flags that do not fit
  wire  [23:0] err_word   = {CODE_DEFECT, diag_bits, 8'h00} & region_msk;
  wire  [15:0] chan_val   = slot_speed ? speed_data : position_data;
  wire  [23:0] data_word  = {chan_val, 8'h00} & region_msk;

  wire  [5:0]  ph3_low    = act_detail_r ? (fault ? diag_bits : 6'h00)
                                         : (fault ? 6'h00 : 6'h3f);
  wire  [23:0] ph3_word   = {(fault ? CODE_DEFECT : CODE_READY), ph3_low, 8'h00};

  // repeat count is twice the field plus two
  wire  [8:0]  ph3_total  = {proto1_r[REP_HI:REP_LO], 1'b0} + 9'd1;

  // status bit carries errors only when enabled, except in phase three where it always follows the fault
  wire         stat_err   = act_cfg_r[BIT_ERR_STATUS] && fault;

  frame_t      frame_nxt;
  always_comb
  begin
    frame_nxt                  = frame_r;
    frame_nxt.slot             = slot_r;
    frame_nxt.is_speed         = slot_speed;
    frame_nxt.phase3           = ph3_r;
    frame_nxt.parity_sel       = act_cfg_r[BIT_PARITY];
    if (ph3_r)
    begin
      // error flag with sixteen-bit status message
      frame_nxt.data             = ph3_word;
      frame_nxt.width            = PH3_WIDTH;
      frame_nxt.status_en        = 1'b1;
      frame_nxt.frame_error_flag = fault;
    end
    else
    begin
      frame_nxt.data             = fault ? err_word : data_word;
      frame_nxt.width            = region_w;
      frame_nxt.status_en        = act_cfg_r[BIT_STATUS_EN];
      frame_nxt.frame_error_flag = act_cfg_r[BIT_STATUS_EN] && stat_err;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (run_rise)
          state_nxt = ST_WAIT;
      ST_WAIT:
        if (!run_en)
          state_nxt = ST_IDLE;
        else if (trigger)
          state_nxt = ST_EMIT;
      ST_EMIT:
        if (slot_r == last_slot)
          state_nxt = run_en ? ST_WAIT : ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // register file
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      out_cfg_r <= OUT_CFG_RST;
      proto1_r  <= PROTO1_RST;
      proto2_r  <= PROTO2_RST;
      ctrl_r    <= 2'b00;
    end
    else
    begin
      if (wr_out_cfg)
        out_cfg_r <= wdata;
      if (wr_proto1)
        proto1_r <= wdata;
      if (wr_proto2)
        proto2_r <= wdata;
      if (wr_ctrl)
        ctrl_r <= wdata[1:0];
    end
  end

  // read data stands one cycle, zero otherwise
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata_r <= 16'h0000;
    else
      rdata_r <= rd_stb ? rd_mux : 16'h0000;
  end

  // sync pin passes two flops, edge taken after the second
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
      sync_d_r <= 1'b0;
    end
    else
    begin
      sync_m_r <= sync_pin;
      sync_s_r <= sync_m_r;
      sync_d_r <= sync_s_r;
    end
  end

  // run bit history for the start edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      run_d_r <= 1'b0;
    else
      run_d_r <= run_en;
  end

  // bit clock enable, takes the written rate at its next reload
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bit_cnt_r  <= 10'h000;
      bit_tick_r <= 1'b0;
    end
    else
    begin
      bit_cnt_r  <= bit_hit ? bit_load : bit_cnt_r - 10'd1;
      bit_tick_r <= bit_hit;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      period_cnt_r <= '0;
    // runs on through emission so frames sit exactly one period apart
    else if (state_r == ST_IDLE || period_hit)
      period_cnt_r <= period_load;
    else
      period_cnt_r <= period_cnt_r - PW'(1);
  end

  // group boundaries
  wire         emit_now   = (state_r == ST_EMIT);
  wire         emit_last  = emit_now && (slot_r == last_slot);
  wire         run_start  = (state_r == ST_IDLE) && run_rise;
  wire         ph3_done   = (ph3_left_r == 9'd0);

  // state and slot counter
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      slot_r  <= 2'd0;
    end
    else
    begin
      state_r <= state_nxt;
      if (emit_last)
        slot_r <= 2'd0;
      else if (emit_now)
        slot_r <= slot_r + 2'd1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      act_cfg_r    <= OUT_CFG_RST;
      act_detail_r <= 1'b0;
    end
    else if (!emit_now)
    begin
      act_cfg_r    <= out_cfg_r;
      act_detail_r <= proto2_r[BIT_DETAIL_SEL];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ph3_r      <= 1'b0;
      ph3_left_r <= 9'd0;
    end
    else if (run_start)
    begin
      ph3_r      <= ctrl_r[CTRL_PH3_EN];
      ph3_left_r <= ph3_total;
    end
    else if (emit_last && ph3_r)
    begin
      // stays at zero so the status word does not wrap
      ph3_left_r <= ph3_done ? 9'd0 : ph3_left_r - 9'd1;
      if (ph3_done)
        ph3_r <= 1'b0;
    end
  end

  // frame output
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      frame_r       <= '0;
      frame_valid_r <= 1'b0;
    end
    else
    begin
      frame_valid_r <= emit_now;
      if (emit_now)
        frame_r <= frame_nxt;
    end
  end

  // line settings follow the active copy
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      line_cfg_r <= '0;
    else
    begin
      line_cfg_r.baud_hi        <= act_cfg_r[BIT_BAUD];
      line_cfg_r.current_double <= act_cfg_r[BIT_CURRENT];
      line_cfg_r.sync_mode      <= act_cfg_r[BIT_SYNC];
      line_cfg_r.nibble_reps    <= {1'b0, act_cfg_r[NIB_HI:NIB_LO]} + 3'd1;
    end
  end

  assign rdata       = rdata_r;
  assign frame       = frame_r;
  assign frame_valid = frame_valid_r;
  assign line_cfg    = line_cfg_r;
  assign bit_tick    = bit_tick_r;

endmodule : psi5_frame_content

// *** dv/psi5_frame_content_checker.sv ***
// port-level assertions for the frame content block
module psi5_frame_content_checker
  import psi5_content_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rdata,
  input wire logic [15:0] position_data,
  input wire logic [15:0] speed_data,
  input wire diag_t       diag_flags,
  input wire logic        sync_pin,
  input wire frame_t      frame,
  input wire logic        frame_valid,
  input wire line_cfg_t   line_cfg,
  input wire logic        bit_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_ph3_code: assert property (frame_valid && frame.phase3 |-> frame.data[23:14] ==
    (frame.frame_error_flag ? CODE_DEFECT : CODE_READY)) else $error("phase three code wrong");
  chk_ph3_width: assert property (frame_valid && frame.phase3 |-> frame.width == PH3_WIDTH)
    else $error("phase three width wrong");
  chk_width_range: assert property (frame_valid |-> frame.width >= 5'd9 && frame.width <= 5'd24)
    else $error("region width out of range");
  chk_low_zero: assert property (frame_valid |-> (frame.data & (24'hffffff >> frame.width)) == 0)
    else $error("bits below region not zero");
  chk_slot_seq: assert property (frame_valid && frame.slot != 2'd0 |-> $past(frame_valid))
    else $error("slot word not consecutive");
  chk_speed_slot: assert property (frame_valid && frame.is_speed |-> frame.slot != 2'd0)
    else $error("speed in first slot");
  chk_group_stable: assert property (frame_valid && frame.slot != 2'd0 |->
    $stable(frame.parity_sel) && $stable(line_cfg)) else $error("settings changed in group");
  chk_tick_gap: assert property (bit_tick |=> !bit_tick [*8])
    else $error("bit tick too fast");
  cov_ph3: cover property (frame_valid && frame.phase3);
  cov_speed: cover property (frame_valid && frame.is_speed && frame.slot == 2'd2);
  cov_fault: cover property (frame_valid && frame.width == 5'd24 && |diag_flags);
endmodule : psi5_frame_content_checker

// *** dv/ecu_rx_model.sv ***
// receiver side model: sync trigger and bit period meter
module ecu_rx_model
(
  input wire logic        clk,
  input wire logic        kick,
  input wire logic        bit_tick,
  output logic            sync_pin,
  output logic     [15:0] bit_gap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt;
  initial
  begin
    sync_pin = 1'b0;
    bit_gap = 16'h0000;
    cnt = 16'h0000;
  end
  always @(posedge clk)
  begin
    if (kick)
      sync_pin <= 1'b1;
    else if (sync_pin)
      sync_pin <= (cnt[1:0] != 2'b11);
  end
  always @(posedge clk)
  begin
    cnt <= bit_tick ? 16'h0001 : cnt + 16'h0001;
    if (bit_tick)
      bit_gap <= cnt;
  end
endmodule : ecu_rx_model

// *** dv/tb_top.sv ***
// self-checking bench for the frame content block
module tb_top;
  import psi5_content_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, wr_stb = 0, rd_stb = 0, kick = 0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata, bit_gap, rv;
  logic [15:0] position_data = 16'h1234, speed_data = 16'habcd;
  diag_t       diag_flags = '0;
  logic        sync_pin, frame_valid, bit_tick;
  frame_t      frame;
  line_cfg_t   line_cfg;
  int          n_fail = 0, num_checks = 0, cyc = 0;
  always #4 clk = ~clk;
  psi5_frame_content #(.PERIOD0_CYC(40), .PERIOD1_CYC(30), .PERIOD2_CYC(20), .PERIOD3_CYC(16))
    u_psi5_frame_content (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .position_data(position_data),
    .speed_data(speed_data), .diag_flags(diag_flags), .sync_pin(sync_pin), .frame(frame),
    .frame_valid(frame_valid), .line_cfg(line_cfg), .bit_tick(bit_tick));
  ecu_rx_model u_ecu_rx_model (.clk(clk), .kick(kick), .bit_tick(bit_tick),
    .sync_pin(sync_pin), .bit_gap(bit_gap));
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task wf;
    int i;
    for (i = 0; i < 2000; i++)
    begin
      @(posedge clk);
      #1;
      if (frame_valid === 1'b1)
        return;
    end
    chk(24'h0, 24'h1);
  endtask : wf
  task t_regs;
    wr(OFS_OUT_CFG, 16'h0837);
    rd(OFS_OUT_CFG, rv);
    chk(rv, 16'h0837);
    rd(8'h20, rv);
    chk(rv, 16'h0000);
    rd(OFS_ACTIVE_CFG, rv);
    chk(rv, 16'h0837);
    repeat (2100) @(posedge clk);
    chk(line_cfg, {1'b0, 1'b1, 1'b0, 3'd4});
    chk(bit_gap, BIT_CYC_LO);
  endtask : t_regs
  task t_fault(input logic [15:0] cfg, input logic [4:0] w, input int per);
    logic [23:0] e;
    int c;
    e = {CODE_DEFECT, diag_flags, 8'h00} & ~(24'hffffff >> w);
    wr(OFS_OUT_CFG, cfg);
    wf(); wf();
    chk(frame.width, w);
    chk(frame.data, e);
    chk(frame.parity_sel, cfg[BIT_PARITY]);
    chk(frame.status_en, cfg[BIT_STATUS_EN]);
    chk(frame.frame_error_flag, cfg[BIT_STATUS_EN] && cfg[BIT_ERR_STATUS] && |diag_flags);
    c = 0;
    do
    begin
      @(posedge clk);
      #1;
      c++;
    end
    while (frame_valid !== 1'b1 && c < 100);
    chk(c, per);
  endtask : t_fault
  task t_ph3(input logic [15:0] p1, p2, input diag_t d, input logic [15:0] e, input int n);
    int k;
    wr(OFS_CTRL, 16'h0000);
    diag_flags <= d;
    repeat (100) @(posedge clk);
    wr(OFS_PROTO1, p1);
    wr(OFS_PROTO2, p2);
    wr(OFS_CTRL, 16'h0003);
    k = 0;
    wf();
    while (frame.phase3 === 1'b1 && k < 300)
    begin
      k++;
      chk(frame.data[23:8], e);
      chk(frame.frame_error_flag, |d);
      wf();
    end
    chk(k, n);
  endtask : t_ph3
  task t_sync;
    int i, c;
    wr(OFS_CTRL, 16'h0000);
    diag_flags <= '0;
    repeat (100) @(posedge clk);
    wr(OFS_OUT_CFG, 16'hb107);
    wr(OFS_CTRL, 16'h0001);
    c = 0;
    for (i = 0; i < 1800; i++)
    begin
      @(posedge clk);
      c += frame_valid;
    end
    chk(c, 0);
    chk(line_cfg, {1'b1, 1'b0, 1'b1, 3'd1});
    chk(bit_gap, BIT_CYC_HI);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    wf();
    for (i = 0; i < 3; i++)
    begin
      chk({frame_valid, frame.slot, frame.is_speed}, {1'b1, 2'(i), i == 2});
      chk(frame.data[23:8], i == 2 ? speed_data : position_data);
      @(posedge clk);
      #1;
    end
  endtask : t_sync
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      finish_test();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    diag_flags <= 6'b100001;
    wr(OFS_CTRL, 16'h0001);
    t_fault(16'h00c1, 5'd10, 16);
    t_fault(16'h4687, 5'd16, 20);
    t_fault(16'h00cf, 5'd24, 16);
    t_ph3(16'h0200, 16'h0000, 6'b000000, {CODE_READY, 6'h3f}, 4);
    t_ph3(16'h0000, 16'h0080, 6'b001000, {CODE_DEFECT, 6'h08}, 2);
    t_sync();
    finish_test();
  end
endmodule : tb_top
bind psi5_frame_content psi5_frame_content_checker u_psi5_frame_content_checker (
  .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .position_data(position_data), .speed_data(speed_data),
  .diag_flags(diag_flags), .sync_pin(sync_pin), .frame(frame), .frame_valid(frame_valid),
  .line_cfg(line_cfg), .bit_tick(bit_tick));
